// ### afs_consts.svh
`ifndef AFS_CONSTS_SVH
`define AFS_CONSTS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define AFS_OFS_ALARM_CFG 8'h00
`define AFS_OFS_OUTPUT_CFG 8'h04
`define AFS_OFS_TUNING_CFG 8'h08
`define AFS_OFS_SP_LIMITS 8'h0c
`define AFS_OFS_SETPOINT 8'h10
`define AFS_OFS_PV_OFFSET 8'h14
`define AFS_OFS_SOURCE_CFG 8'h18
`define AFS_OFS_STATUS 8'h1c
`define AFS_OFS_PV_ONE 8'h20

////////////////////////////////////////////////////////////////////////////////
// Field positions of the alarm configuration word
`define AFS_F_A1_FN 0
`define AFS_F_A1_MODE 4
`define AFS_F_A2_FN 8
`define AFS_F_A2_MODE 12
`define AFS_F_A1_FAIL_ON 16
`define AFS_F_A2_FAIL_ON 17
`define AFS_F_OUTPUT2_FUNCTION_SEL_FN 20
`define AFS_F_O1_DIRECT 24
`define AFS_F_MANUAL 28
`define AFS_F_CALIBRATE 29

// Field positions of the output configuration word
`define AFS_F_O1_LEVEL 0
`define AFS_F_O1_BUMPLESS 12
`define AFS_F_O2_LEVEL 16
`define AFS_F_O2_BUMPLESS 28

// Field positions of the source configuration word
`define AFS_F_PV_SRC 0
`define AFS_F_SP_SRC 4

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define AFS_RST_SP_LOW 16'h8000
`define AFS_RST_SP_HIGH 16'h7fff
`define AFS_RST_PB1 16'h00b4
`define AFS_RST_TI1 16'h0064

////////////////////////////////////////////////////////////////////////////////
// Levels and thresholds
`define AFS_LEVEL_FULL 10'h3e8
`define AFS_IN_LOW_UA 16'h03e8
`define AFS_IN_LOW_MV 16'h00fa

////////////////////////////////////////////////////////////////////////////////
// Timing
`define AFS_CLK_HZ 250000000
`define AFS_POWER_START_MS 2500
`define AFS_LB_MAX_SEC 120

`endif

// ### afs_loop_break.sv
`timescale 1ns/100ps
`include "afs_consts.svh"

module afs_loop_break
	import afs_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic secondTick,
	input wire logic [15:0] integralSeconds,
	input wire logic driveAtMax,
	input wire logic driveAtMin,
	input wire afs_value_t processValue,
	output logic loopBroken
);

	logic [7:0] windowSec;
	logic [7:0] elapsedSec;
	afs_value_t refValue;
	logic moved;

	////////////////////////////////////////////////////////////////////////////
	// R3: double integral, capped
	always_comb
	begin
		if (integralSeconds >= 16'(`AFS_LB_MAX_SEC / 2))
			windowSec = 8'(`AFS_LB_MAX_SEC);
		else
			windowSec = {integralSeconds[6:0], 1'b0};
		moved = (driveAtMax && processValue > refValue) ||
			(driveAtMin && processValue < refValue);
	end

	////////////////////////////////////////////////////////////////////////////
	// R4: saturation without response
	always_ff @(posedge clk)
	begin
		if (rst || !(driveAtMax || driveAtMin) || moved)
		begin
			elapsedSec <= 8'h00;
			loopBroken <= 1'b0;
			refValue <= rst ? 16'sh0000 : processValue;
		end
		else if (secondTick)
		begin
			if (elapsedSec >= windowSec)
				loopBroken <= 1'b1;
			else
				elapsedSec <= elapsedSec + 8'h01;
		end
	end

endmodule

// ### afs_pkg.sv
package afs_pkg;

	typedef enum logic [1:0]
	{
		AFS_FN_PROCESS = 2'h0,
		AFS_FN_LOOP_BREAK = 2'h1,
		AFS_FN_SENSOR_BREAK = 2'h2,
		AFS_FN_DWELL_TIMER = 2'h3
	} afs_alarm_fn_t;

	typedef enum logic [1:0]
	{
		AFS_MODE_NORMAL = 2'h0,
		AFS_MODE_LATCHING = 2'h1,
		AFS_MODE_HOLDING = 2'h2,
		AFS_MODE_LATCH_HOLD = 2'h3
	} afs_alarm_mode_t;

	typedef enum logic [1:0]
	{
		AFS_OUTPUT2_FUNCTION_SEL_HEATING = 2'h0,
		AFS_OUTPUT2_FUNCTION_SEL_COOLING = 2'h1,
		AFS_OUTPUT2_FUNCTION_SEL_ALARM = 2'h2,
		AFS_OUTPUT2_FUNCTION_SEL_NONE = 2'h3
	} afs_output2_function_sel_fn_t;

	typedef enum logic [1:0]
	{
		AFS_PV_ONE = 2'h0,
		AFS_PV_TWO = 2'h1,
		AFS_PV_ONE_MINUS_TWO = 2'h2,
		AFS_PV_TWO_MINUS_ONE = 2'h3
	} afs_pv_src_t;

	typedef enum logic [1:0]
	{
		AFS_SP_LOCAL = 2'h0,
		AFS_SP_PV_ONE = 2'h1,
		AFS_SP_PV_TWO = 2'h2,
		AFS_SP_SPARE = 2'h3
	} afs_sp_src_t;

	typedef enum logic [1:0]
	{
		AFS_RANGE_OTHER = 2'h0,
		AFS_RANGE_MA_4_20 = 2'h1,
		AFS_RANGE_V_1_5 = 2'h2,
		AFS_RANGE_SPARE = 2'h3
	} afs_range_t;

	typedef logic signed [15:0] afs_value_t;
	typedef logic [9:0] afs_level_t;

endpackage

// ### afs_props.sv
`timescale 1ns/100ps

module afs_props
	import afs_pkg::*;
#(
	parameter int POWER_START_CYCLES = 20
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic input1Open,
	input wire logic input2Open,
	input wire afs_range_t input1Range,
	input wire afs_range_t input2Range,
	input wire logic converterFault,
	input wire logic failureMode,
	input wire logic transferActive
);
	logic [31:0] startCount;

	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);

	// Cycles since reset release
	always_ff @(posedge clk)
	begin
		if (rst)
			startCount <= 32'h0;
		else if (startCount < POWER_START_CYCLES)
			startCount <= startCount + 32'h1;
	end

	////////////////////////////////////////
	a_ready_after_setup:
		assert property (psel && !penable |=> pready) else $error("no ready after setup");
	a_ready_single:
		assert property (pready |=> !pready) else $error("ready held too long");
	a_err_with_ready:
		assert property (pslverr |-> pready && psel && penable) else $error("stray error");
	a_conv_fail:
		assert property (converterFault |=> failureMode) else $error("fault not seen");
	a_fail_xfer:
		assert property (failureMode |-> transferActive) else $error("no transfer in failure");
	a_start_window:
		assert property (startCount + 1 < POWER_START_CYCLES |-> transferActive)
		else $error("power start window short");
	a_fail_cause:
		assert property ($rose(failureMode) |-> $past(converterFault) || $past(input1Open)
			|| $past(input2Open) || $past(input1Range) != AFS_RANGE_OTHER
			|| $past(input2Range) != AFS_RANGE_OTHER)
		else $error("failure without cause");
	a_fault_clear:
		assert property (!converterFault && !input1Open && !input2Open
			&& input1Range == AFS_RANGE_OTHER && input2Range == AFS_RANGE_OTHER |=> !failureMode)
		else $error("failure without fault");
endmodule

bind afs_top afs_props #(.POWER_START_CYCLES(POWER_START_CYCLES)) props (.clk(clk), .rst(rst),
	.psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
	.input1Open(input1Open), .input2Open(input2Open), .input1Range(input1Range),
	.input2Range(input2Range), .converterFault(converterFault),
	.failureMode(failureMode), .transferActive(transferActive));

// ### afs_top.sv
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/100ps
`include "afs_consts.svh"

// Overview of operation
// R1: Alarm selecting loop break acts as one; alarm 2 only when output 2 is alarm.
// R2: Loop break alarm never applies holding behaviour.
// R3: Loop break window is twice first integral time, at most 120 seconds.
// R4: Drive saturated and process value not moving over window raises loop break.
// R5: Sensor break alarm asserts at once on failure mode, converter fault included.
// R6: Sensor break alarm never applies holding behaviour.
// R7: First set point is confined between low and high limits.
// R8: Signed offset is added to process value one only.
// R9: Input 1 break or low reading flags break and failure when input 1 used.
// R10: Input 2 break or low reading flags break and failure when input 2 used.
// R11: Converter fault sets its flag and enters failure mode.
// R12: Outputs transfer during 2.5 s power start, failure, manual or calibration.
// R13: Proportional output 1 with bumpless uses averaged drive during transfer.
// R14: Proportional output 1 with fixed level uses that level during transfer.
// R15: On-off output 1 goes off for reverse, on for direct, during transfer.
// R16: Cooling output 2 with bumpless uses averaged output 2 drive during transfer.
// R17: Cooling output 2 with fixed level uses that level during transfer.
// R18: Alarms transfer only in failure mode, to their preset on or off state.
// R19: Loop or sensor break alarms turn on in failure; dwell timer does not transfer.
// R20: Normal alarm follows its condition.
// R21: Latching alarm stays on until event clear or power removal.
// R22: Power start window is timed by a counter started at reset release.

module afs_top
	import afs_pkg::*;
#(
	parameter int POWER_START_CYCLES = `AFS_POWER_START_MS * (`AFS_CLK_HZ / 1000),
	parameter int SECOND_CYCLES = `AFS_CLK_HZ
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire afs_value_t processValueRaw,
	input wire afs_value_t processValueTwo,
	input wire logic input1Open,
	input wire afs_range_t input1Range,
	input wire logic [15:0] input1Measure,
	input wire logic input2Open,
	input wire afs_range_t input2Range,
	input wire logic [15:0] input2Measure,
	input wire logic converterFault,
	input wire afs_level_t output1DriveLevel,
	input wire afs_level_t output2DriveLevel,
	input wire afs_level_t output1AveragedLevel,
	input wire afs_level_t output2AveragedLevel,
	input wire logic [1:0] alarmCondition,
	input wire logic [1:0] setpointReached,
	input wire logic latchClearEvent,
	output afs_level_t output1Level,
	output logic output1On,
	output afs_level_t output2Level,
	output logic [1:0] alarmOut,
	output logic failureMode,
	output logic transferActive,
	output afs_value_t processValueOne,
	output afs_value_t firstSetpoint
);

	afs_alarm_fn_t alarmFn [2];
	afs_alarm_mode_t alarmMode [2];
	logic [1:0] alarmFailOn;
	afs_output2_function_sel_fn_t output2FunctionSel;
	logic output1Direct;
	logic manualMode;
	logic calibrationMode;
	afs_level_t output1FailureSetting;
	logic output1Bumpless;
	afs_level_t output2FailureSetting;
	logic output2Bumpless;
	logic [15:0] proportionalBandFirst;
	logic [15:0] integralTimeFirst;
	afs_value_t setpointLowLimit;
	afs_value_t setpointHighLimit;
	afs_value_t setpointRequest;
	afs_value_t processOffset;
	afs_pv_src_t processValueSourceSel;
	afs_sp_src_t setpointSourceSel;
	logic input1BreakFlag;
	logic input2BreakFlag;
	logic converterFaultFlag;
	logic powerStart;
	logic [31:0] powerCount;
	logic [31:0] secondCount;
	logic secondTick;
	logic loopBroken;
	logic [1:0] alarmArmed;
	logic [1:0] alarmLatched;
	logic [1:0] alarmEnabled;
	logic [1:0] next_alarm;
	logic accessWrite;
	logic [31:0] readWord;
	logic readMapped;
	logic input1Used;
	logic input2Used;
	logic input1Low;
	logic input2Low;
	logic next_transfer;
	logic next_failure;

	////////////////////////////////////////////////////////////////////////////
	// APB slave, no wait states
	assign accessWrite = psel && penable && pready && pwrite;

	always_comb
	begin
		readWord = 32'h0000_0000;
		readMapped = 1'b1;
		unique case (paddr)
			`AFS_OFS_ALARM_CFG:
			begin
				readWord[`AFS_F_A1_FN +: 2] = alarmFn[0];
				readWord[`AFS_F_A1_MODE +: 2] = alarmMode[0];
				readWord[`AFS_F_A2_FN +: 2] = alarmFn[1];
				readWord[`AFS_F_A2_MODE +: 2] = alarmMode[1];
				readWord[`AFS_F_A1_FAIL_ON] = alarmFailOn[0];
				readWord[`AFS_F_A2_FAIL_ON] = alarmFailOn[1];
				readWord[`AFS_F_OUTPUT2_FUNCTION_SEL_FN +: 2] = output2FunctionSel;
				readWord[`AFS_F_O1_DIRECT] = output1Direct;
				readWord[`AFS_F_MANUAL] = manualMode;
				readWord[`AFS_F_CALIBRATE] = calibrationMode;
			end
			`AFS_OFS_OUTPUT_CFG:
			begin
				readWord[`AFS_F_O1_LEVEL +: 10] = output1FailureSetting;
				readWord[`AFS_F_O1_BUMPLESS] = output1Bumpless;
				readWord[`AFS_F_O2_LEVEL +: 10] = output2FailureSetting;
				readWord[`AFS_F_O2_BUMPLESS] = output2Bumpless;
			end
			`AFS_OFS_TUNING_CFG:
				readWord = {integralTimeFirst, proportionalBandFirst};
			`AFS_OFS_SP_LIMITS:
				readWord = {setpointHighLimit, setpointLowLimit};
			`AFS_OFS_SETPOINT:
				readWord = {16'h0000, firstSetpoint};
			`AFS_OFS_PV_OFFSET:
				readWord = {16'h0000, processOffset};
			`AFS_OFS_SOURCE_CFG:
			begin
				readWord[`AFS_F_PV_SRC +: 2] = processValueSourceSel;
				readWord[`AFS_F_SP_SRC +: 2] = setpointSourceSel;
			end
			`AFS_OFS_STATUS:
				readWord = {22'h000000, loopBroken, powerStart, alarmOut, transferActive,
					failureMode, converterFaultFlag, input2BreakFlag, input1BreakFlag, 1'b0};
			`AFS_OFS_PV_ONE:
				readWord = {16'h0000, processValueOne};
			default:
				readMapped = 1'b0;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !readMapped;
			if (psel && !penable && !pwrite)
				prdata <= readWord;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Configuration registers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			alarmFn[0] <= AFS_FN_PROCESS;
			alarmFn[1] <= AFS_FN_PROCESS;
			alarmMode[0] <= AFS_MODE_NORMAL;
			alarmMode[1] <= AFS_MODE_NORMAL;
			alarmFailOn <= 2'h0;
			output2FunctionSel <= AFS_OUTPUT2_FUNCTION_SEL_HEATING;
			output1Direct <= 1'b0;
			manualMode <= 1'b0;
			calibrationMode <= 1'b0;
			output1FailureSetting <= 10'h000;
			output1Bumpless <= 1'b0;
			output2FailureSetting <= 10'h000;
			output2Bumpless <= 1'b0;
			proportionalBandFirst <= `AFS_RST_PB1;
			integralTimeFirst <= `AFS_RST_TI1;
			setpointLowLimit <= `AFS_RST_SP_LOW;
			setpointHighLimit <= `AFS_RST_SP_HIGH;
			setpointRequest <= 16'sh0000;
			processOffset <= 16'sh0000;
			processValueSourceSel <= AFS_PV_ONE;
			setpointSourceSel <= AFS_SP_LOCAL;
		end
		else if (accessWrite)
		begin
			unique case (paddr)
				`AFS_OFS_ALARM_CFG:
				begin
					alarmFn[0] <= afs_alarm_fn_t'(pwdata[`AFS_F_A1_FN +: 2]);
					alarmMode[0] <= afs_alarm_mode_t'(pwdata[`AFS_F_A1_MODE +: 2]);
					alarmFn[1] <= afs_alarm_fn_t'(pwdata[`AFS_F_A2_FN +: 2]);
					alarmMode[1] <= afs_alarm_mode_t'(pwdata[`AFS_F_A2_MODE +: 2]);
					alarmFailOn <= pwdata[`AFS_F_A2_FAIL_ON:`AFS_F_A1_FAIL_ON];
					output2FunctionSel <= afs_output2_function_sel_fn_t'(pwdata[`AFS_F_OUTPUT2_FUNCTION_SEL_FN +: 2]);
					output1Direct <= pwdata[`AFS_F_O1_DIRECT];
					manualMode <= pwdata[`AFS_F_MANUAL];
					calibrationMode <= pwdata[`AFS_F_CALIBRATE];
				end
				`AFS_OFS_OUTPUT_CFG:
				begin
					output1FailureSetting <= pwdata[`AFS_F_O1_LEVEL +: 10];
					output1Bumpless <= pwdata[`AFS_F_O1_BUMPLESS];
					output2FailureSetting <= pwdata[`AFS_F_O2_LEVEL +: 10];
					output2Bumpless <= pwdata[`AFS_F_O2_BUMPLESS];
				end
				`AFS_OFS_TUNING_CFG:
				begin
					proportionalBandFirst <= pwdata[15:0];
					integralTimeFirst <= pwdata[31:16];
				end
				`AFS_OFS_SP_LIMITS:
				begin
					setpointLowLimit <= pwdata[15:0];
					setpointHighLimit <= pwdata[31:16];
				end
				`AFS_OFS_SETPOINT:
					setpointRequest <= pwdata[15:0];
				`AFS_OFS_PV_OFFSET:
					processOffset <= pwdata[15:0];
				`AFS_OFS_SOURCE_CFG:
				begin
					processValueSourceSel <= afs_pv_src_t'(pwdata[`AFS_F_PV_SRC +: 2]);
					setpointSourceSel <= afs_sp_src_t'(pwdata[`AFS_F_SP_SRC +: 2]);
				end
				default:
				begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Set point and process value
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			firstSetpoint <= 16'sh0000;
			processValueOne <= 16'sh0000;
		end
		else
		begin
			// R7: clamp to limits
			if (setpointRequest < setpointLowLimit)
				firstSetpoint <= setpointLowLimit;
			else if (setpointRequest > setpointHighLimit)
				firstSetpoint <= setpointHighLimit;
			else
				firstSetpoint <= setpointRequest;
			// R8: offset on value one
			processValueOne <= processValueRaw + processOffset;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Timers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			powerCount <= 32'h0000_0000;
			powerStart <= 1'b1;
			secondCount <= 32'h0000_0000;
			secondTick <= 1'b0;
		end
		else
		begin
			// R22: power start count
			if (powerStart)
			begin
				powerCount <= powerCount + 32'h0000_0001;
				powerStart <= powerCount < 32'(POWER_START_CYCLES - 1);
			end
			secondTick <= secondCount == 32'(SECOND_CYCLES - 1);
			if (secondCount == 32'(SECOND_CYCLES - 1))
				secondCount <= 32'h0000_0000;
			else
				secondCount <= secondCount + 32'h0000_0001;
		end
	end

	afs_loop_break loopCheck
	(
		.clk(clk),
		.rst(rst),
		.secondTick(secondTick),
		.integralSeconds(integralTimeFirst),
		.driveAtMax(output1DriveLevel >= `AFS_LEVEL_FULL),
		.driveAtMin(output1DriveLevel == 10'h000),
		.processValue(processValueOne),
		.loopBroken(loopBroken)
	);

	////////////////////////////////////////////////////////////////////////////
	// Failure detection
	always_comb
	begin
		input1Used = processValueSourceSel != AFS_PV_TWO || setpointSourceSel == AFS_SP_PV_ONE;
		input2Used = processValueSourceSel != AFS_PV_ONE || setpointSourceSel == AFS_SP_PV_TWO;
		input1Low = (input1Range == AFS_RANGE_MA_4_20 && input1Measure < `AFS_IN_LOW_UA) ||
			(input1Range == AFS_RANGE_V_1_5 && input1Measure < `AFS_IN_LOW_MV);
		input2Low = (input2Range == AFS_RANGE_MA_4_20 && input2Measure < `AFS_IN_LOW_UA) ||
			(input2Range == AFS_RANGE_V_1_5 && input2Measure < `AFS_IN_LOW_MV);
		next_failure = ((input1Open || input1Low) && input1Used) ||
			((input2Open || input2Low) && input2Used) || converterFault;
		next_transfer = powerStart || next_failure || manualMode || calibrationMode;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			input1BreakFlag <= 1'b0;
			input2BreakFlag <= 1'b0;
			converterFaultFlag <= 1'b0;
			failureMode <= 1'b0;
			transferActive <= 1'b1;
		end
		else
		begin
			// R9: input 1 break
			input1BreakFlag <= (input1Open || input1Low) && input1Used;
			// R10: input 2 break
			input2BreakFlag <= (input2Open || input2Low) && input2Used;
			// R11: converter fault
			converterFaultFlag <= converterFault;
			failureMode <= next_failure;
			// R12: transfer conditions
			transferActive <= next_transfer;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Output drive
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			output1Level <= 10'h000;
			output1On <= 1'b0;
			output2Level <= 10'h000;
		end
		else if (next_transfer)
		begin
			if (proportionalBandFirst != 16'h0000)
			begin
				// R13: bumpless output 1
				if (output1Bumpless)
					output1Level <= output1AveragedLevel;
				// R14: fixed output 1
				else if (output1FailureSetting > `AFS_LEVEL_FULL)
					output1Level <= `AFS_LEVEL_FULL;
				else
					output1Level <= output1FailureSetting;
				output1On <= 1'b0;
			end
			else
			begin
				// R15: on-off by action
				output1Level <= output1Direct ? `AFS_LEVEL_FULL : 10'h000;
				output1On <= output1Direct;
			end
			if (output2FunctionSel == AFS_OUTPUT2_FUNCTION_SEL_COOLING)
			begin
				// R16: bumpless output 2
				if (output2Bumpless)
					output2Level <= output2AveragedLevel;
				// R17: fixed output 2
				else if (output2FailureSetting > `AFS_LEVEL_FULL)
					output2Level <= `AFS_LEVEL_FULL;
				else
					output2Level <= output2FailureSetting;
			end
			else
				output2Level <= output2DriveLevel;
		end
		else
		begin
			output1Level <= output1DriveLevel;
			output1On <= output1DriveLevel != 10'h000;
			output2Level <= output2DriveLevel;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Alarm channels
	// R1: alarm 2 needs output 2 as alarm
	assign alarmEnabled = {output2FunctionSel == AFS_OUTPUT2_FUNCTION_SEL_ALARM, 1'b1};

	for (genvar i = 0; i < 2; i++)
	begin : gAlarm
		logic cond;
		logic breakFn;
		logic holds;
		logic latches;

		always_comb
		begin
			breakFn = alarmFn[i] == AFS_FN_LOOP_BREAK || alarmFn[i] == AFS_FN_SENSOR_BREAK;
			// R1: loop break source
			// R5: sensor break source
			unique case (alarmFn[i])
				AFS_FN_LOOP_BREAK:
					cond = loopBroken;
				AFS_FN_SENSOR_BREAK:
					cond = next_failure;
				default:
					cond = alarmCondition[i];
			endcase
			// R2: no holding for loop break
			// R6: no holding for sensor break
			holds = !breakFn && (alarmMode[i] == AFS_MODE_HOLDING ||
				alarmMode[i] == AFS_MODE_LATCH_HOLD);
			latches = alarmMode[i] == AFS_MODE_LATCHING || alarmMode[i] == AFS_MODE_LATCH_HOLD;
			// R18: failure preset
			// R19: break alarms on, timer exempt
			if (!alarmEnabled[i])
				next_alarm[i] = 1'b0;
			else if (next_failure && breakFn)
				next_alarm[i] = 1'b1;
			else if (next_failure && alarmFn[i] != AFS_FN_DWELL_TIMER)
				next_alarm[i] = alarmFailOn[i];
			// R20: normal follows condition
			// R21: latched stays on
			else
				next_alarm[i] = (cond && (alarmArmed[i] || !holds)) ||
					(latches && alarmLatched[i]);
		end

		always_ff @(posedge clk)
		begin
			if (rst)
			begin
				alarmArmed[i] <= 1'b0;
				alarmLatched[i] <= 1'b0;
				alarmOut[i] <= 1'b0;
			end
			else
			begin
				if (setpointReached[i])
					alarmArmed[i] <= 1'b1;
				// R21: event input clears latch
				if (cond && (alarmArmed[i] || !holds) && alarmEnabled[i] && latches)
					alarmLatched[i] <= 1'b1;
				else if (latchClearEvent || !latches)
					alarmLatched[i] <= 1'b0;
				alarmOut[i] <= next_alarm[i];
			end
		end
	end

endmodule

// ### afs_top_tb.sv
`timescale 1ns/100ps
`include "afs_consts.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
	$display("Error at %0t: got %h expected %h", $time, g, e); end end

module afs_top_tb
	import afs_pkg::*;
;
	int err_count = 0;
	int samples_checked = 0;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, rerr;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdata;
	logic converterFault = 1'h0, latchClearEvent = 1'h0, output1On, failureMode;
	logic input1Open = 1'h0, input2Open = 1'h0, transferActive;
	afs_value_t processValueRaw = 16'h0000, processValueTwo = 16'h0064;
	afs_value_t processValueOne, firstSetpoint;
	afs_range_t input1Range = AFS_RANGE_OTHER, input2Range = AFS_RANGE_OTHER;
	logic [15:0] input1Measure = 16'h03e8, input2Measure = 16'h03e8;
	afs_level_t output1DriveLevel = 10'h1f4, output2DriveLevel = 10'h1f4;
	afs_level_t output1AveragedLevel = 10'h123, output2AveragedLevel = 10'h0ab;
	afs_level_t output1Level, output2Level;
	logic [1:0] alarmCondition = 2'h0, setpointReached = 2'h0, alarmOut;

	always #2 clk = ~clk;

	afs_top #(.POWER_START_CYCLES(20), .SECOND_CYCLES(10)) dut (.clk(clk), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.processValueRaw(processValueRaw), .processValueTwo(processValueTwo),
		.input1Open(input1Open), .input1Range(input1Range), .input1Measure(input1Measure),
		.input2Open(input2Open), .input2Range(input2Range), .input2Measure(input2Measure),
		.converterFault(converterFault), .output1DriveLevel(output1DriveLevel),
		.output2DriveLevel(output2DriveLevel), .output1AveragedLevel(output1AveragedLevel),
		.output2AveragedLevel(output2AveragedLevel), .alarmCondition(alarmCondition),
		.setpointReached(setpointReached), .latchClearEvent(latchClearEvent),
		.output1Level(output1Level), .output1On(output1On), .output2Level(output2Level),
		.alarmOut(alarmOut), .failureMode(failureMode), .transferActive(transferActive),
		.processValueOne(processValueOne), .firstSetpoint(firstSetpoint));

	////////////////////////////////////////
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// One APB transfer, then one idle edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
		`CHK(rerr, 1'h0)
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		`CHK(rdata, e)
	endtask

	task stop_test;
		$display("Mismatches %0d, comparisons %0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	////////////////////////////////////////
	task t_power;
		cyc(2);
		`CHK(transferActive, 1'h1)
		rd(`AFS_OFS_STATUS, 32'h00000120);
		cyc(30);
		`CHK(transferActive, 1'h0)
	endtask

	task t_regs;
		rd(`AFS_OFS_TUNING_CFG, 32'h006400b4);
		rd(`AFS_OFS_SP_LIMITS, 32'h7fff8000);
		apb(1'h0, 8'h40, 32'h0);
		`CHK(rerr, 1'h1)
		wr(`AFS_OFS_STATUS, 32'hffffffff);
		rd(`AFS_OFS_STATUS, 32'h00000000);
	endtask

	task t_setpoint;
		wr(`AFS_OFS_SP_LIMITS, 32'hfff6fff1);
		wr(`AFS_OFS_SETPOINT, 32'h00000000);
		cyc(3);
		`CHK(firstSetpoint, 16'hfff6)
		wr(`AFS_OFS_SETPOINT, 32'h00008000);
		cyc(3);
		`CHK(firstSetpoint, 16'hfff1)
		wr(`AFS_OFS_SETPOINT, 32'h0000fff3);
		cyc(3);
		`CHK(firstSetpoint, 16'hfff3)
		wr(`AFS_OFS_SP_LIMITS, 32'h7fff8000);
	endtask

	task t_offset;
		processValueRaw <= 16'h00eb;
		wr(`AFS_OFS_PV_OFFSET, 32'h0000ffdd);
		cyc(3);
		`CHK(processValueOne, 16'h00c8)
		rd(`AFS_OFS_PV_ONE, 32'h000000c8);
	endtask

	task t_input;
		input1Range <= AFS_RANGE_MA_4_20;
		input1Measure <= 16'h03e7;
		cyc(3);
		rd(`AFS_OFS_STATUS, 32'h00000032);
		input1Measure <= 16'h03e8;
		cyc(3);
		`CHK(failureMode, 1'h0)
		wr(`AFS_OFS_SOURCE_CFG, 32'h00000001);
		input1Measure <= 16'h03e7;
		input2Range <= AFS_RANGE_V_1_5;
		input2Measure <= 16'h00f9;
		cyc(3);
		rd(`AFS_OFS_STATUS, 32'h00000034);
		input2Measure <= 16'h00fa;
		input1Open <= 1'h1;
		cyc(3);
		`CHK(failureMode, 1'h0)
		input1Range <= AFS_RANGE_OTHER;
		input2Range <= AFS_RANGE_OTHER;
		wr(`AFS_OFS_SOURCE_CFG, 32'h00000000);
		cyc(2);
		`CHK(failureMode, 1'h1)
		input1Open <= 1'h0;
	endtask

	task t_fail;
		wr(`AFS_OFS_ALARM_CFG, 32'h00200102);
		converterFault <= 1'h1;
		cyc(3);
		`CHK(alarmOut, 2'h3)
		rd(`AFS_OFS_STATUS, 32'h000000f8);
		converterFault <= 1'h0;
		cyc(3);
		`CHK(failureMode, 1'h0)
	endtask

	task t_alarm;
		wr(`AFS_OFS_ALARM_CFG, 32'h00210000);
		converterFault <= 1'h1;
		cyc(3);
		`CHK(alarmOut, 2'h1)
		wr(`AFS_OFS_ALARM_CFG, 32'h00200300);
		alarmCondition <= 2'h2;
		cyc(3);
		`CHK(alarmOut, 2'h2)
		alarmCondition <= 2'h0;
		cyc(3);
		`CHK(alarmOut, 2'h0)
		wr(`AFS_OFS_ALARM_CFG, 32'h00000100);
		cyc(2);
		`CHK(alarmOut, 2'h0)
		converterFault <= 1'h0;
		wr(`AFS_OFS_ALARM_CFG, 32'h00000000);
	endtask

	task t_out;
		wr(`AFS_OFS_ALARM_CFG, 32'h10100000);
		wr(`AFS_OFS_OUTPUT_CFG, 32'h100002bc);
		cyc(3);
		`CHK(output1Level, 10'h2bc)
		`CHK(output2Level, 10'h0ab)
		wr(`AFS_OFS_OUTPUT_CFG, 32'h012c1000);
		cyc(3);
		`CHK(output1Level, 10'h123)
		`CHK(output2Level, 10'h12c)
		wr(`AFS_OFS_TUNING_CFG, 32'h00640000);
		wr(`AFS_OFS_ALARM_CFG, 32'h11100000);
		cyc(3);
		`CHK(output1On, 1'h1)
		wr(`AFS_OFS_ALARM_CFG, 32'h10100000);
		cyc(3);
		`CHK(output1On, 1'h0)
		wr(`AFS_OFS_TUNING_CFG, 32'h006400b4);
		wr(`AFS_OFS_ALARM_CFG, 32'h00000000);
		cyc(3);
		`CHK(transferActive, 1'h0)
	endtask

	task t_latch;
		alarmCondition <= 2'h1;
		cyc(3);
		`CHK(alarmOut, 2'h1)
		alarmCondition <= 2'h0;
		cyc(3);
		`CHK(alarmOut, 2'h0)
		wr(`AFS_OFS_ALARM_CFG, 32'h00000010);
		alarmCondition <= 2'h1;
		cyc(3);
		alarmCondition <= 2'h0;
		cyc(3);
		`CHK(alarmOut, 2'h1)
		latchClearEvent <= 1'h1;
		cyc(3);
		latchClearEvent <= 1'h0;
		`CHK(alarmOut, 2'h0)
	endtask

	task t_loop;
		wr(`AFS_OFS_TUNING_CFG, 32'h000200b4);
		wr(`AFS_OFS_ALARM_CFG, 32'h00000021);
		output1DriveLevel <= 10'h3e8;
		cyc(20);
		`CHK(alarmOut, 2'h0)
		cyc(60);
		`CHK(alarmOut, 2'h1)
		output1DriveLevel <= 10'h1f4;
		cyc(3);
		`CHK(alarmOut, 2'h0)
	endtask

	initial
	begin
		cyc(16);
		rst <= 1'h0;
		t_power;
		t_regs;
		t_setpoint;
		t_offset;
		t_input;
		t_fail;
		t_alarm;
		t_out;
		t_latch;
		t_loop;
		stop_test;
	end

	// Cut a hang short
	initial
	begin
		cyc(20000);
		err_count++;
		stop_test;
	end
endmodule
